// [common/dcc_pkg.sv]
// Package: register map, reset values and bus carrier for the DAC calibration bank
package dcc_pkg;

    // Channel organisation
    localparam int NUM_CH     = 32;            // Converter channels
    localparam int GRP_SIZE   = 8;             // Channels per group
    localparam int NUM_GRP    = 4;             // Groups
    localparam int DW         = 16;            // Data word width
    localparam int OFS_W      = 14;            // Offset level width
    localparam int CTRL_W     = 3;             // Control register width

    // Control register fields
    localparam int CTRL_PD    = 0;             // Software power-down
    localparam int CTRL_TSD   = 1;             // Thermal shutdown enable
    localparam int CTRL_AB    = 2;             // Global A/B data routing

    // Global register byte offsets (page 0)
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_GROUP0_OFFSET_LEVEL   = 12'h004;
    localparam logic [11:0] OFF_GROUP123_OFFSET_LEVEL   = 12'h008;
    localparam logic [11:0] OFF_SEL0   = 12'h00C; // Select 0..3 follow
    localparam logic [11:0] OFF_SELALL = 12'h01C; // Global select command
    localparam logic [11:0] OFF_STAT   = 12'h020; // Engine busy

    // Per-channel pages, channel index in adr[6:2]
    localparam logic [3:0]  PG_GLOB    = 4'h0;
    localparam logic [3:0]  PG_DATA    = 4'h1;    // Write routed by A/B bit
    localparam logic [3:0]  PG_RDA     = 4'h2;    // Input A readback
    localparam logic [3:0]  PG_RDB     = 4'h3;    // Input B readback
    localparam logic [3:0]  PG_GAIN    = 4'h4;
    localparam logic [3:0]  PG_OFFT    = 4'h5;

    // Reset values
    localparam logic [15:0] RST_INPUT  = 16'h5554;
    localparam logic [15:0] RST_GAIN   = 16'hFFFF;
    localparam logic [15:0] RST_OFFT   = 16'h8000;
    localparam logic [13:0] RST_OFS    = 14'h1555;
    localparam logic [2:0]  RST_CTRL   = 3'h0;
    localparam logic [7:0]  RST_SEL    = 8'h00;

    // Calibration constants
    localparam logic [18:0] CAL_MID    = 19'h08000; // 2^15 subtracted
    localparam logic [18:0] CAL_MAX    = 19'h0FFFF; // Full scale

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dcc_wb_req_t;

    // Engine states
    typedef enum logic {DCC_IDLE, DCC_RUN} dcc_state_t;

endpackage

// [hdl/dcc_regs.sv]
// DAC calibration register bank with shared calibration engine
`timescale 1ns/10ps
module dcc_regs (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Wishbone slave
    input  wire dcc_pkg::dcc_wb_req_t  wb_req,
    output logic                       wb_ack,
    output logic [31:0]                wb_dat_o,
    // Converter side
    input  wire logic                  load_outputs_n,
    output logic [dcc_pkg::NUM_CH*16-1:0] dac_words,
    output logic [13:0]                group0_offset_level,
    output logic [13:0]                group123_offset_level,
    output logic                       thermal_enable,
    output logic                       power_down
);
    import dcc_pkg::*;

    // Checks below sample on the rising clock and sleep through reset
    default clocking dcc_cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Host-visible registers
    logic [15:0]      in_a_q  [NUM_CH];    // Input data A
    logic [15:0]      in_b_q  [NUM_CH];    // Input data B
    logic [15:0]      gain_q  [NUM_CH];    // Gain trim
    logic [15:0]      offt_q  [NUM_CH];    // Offset trim
    logic [CTRL_W-1:0] ctrl_q;             // Global control
    logic [13:0]      group0_offset_level_q;              // Group 0 offset level
    logic [13:0]      group123_offset_level_q;              // Groups 1-3 offset level
    logic [7:0]       sel_q   [NUM_GRP];   // A/B select per group
    // Hidden registers
    logic [15:0]      cal_a_q [NUM_CH];    // Calibrated A
    logic [15:0]      cal_b_q [NUM_CH];    // Calibrated B
    logic [15:0]      final_q [NUM_CH];    // Final converter word
    logic [NUM_CH-1:0] pend_a_q;           // A recalculation pending
    logic [NUM_CH-1:0] pend_b_q;           // B recalculation pending
    // Engine
    dcc_state_t       state_q;             // Engine state
    logic [5:0]       scan_q;              // {side, channel} scan index
    // Bus
    logic             ack_q;               // Acknowledge
    logic [31:0]      dat_q;               // Read data

    // Bus decode
    logic        req;                      // Request waiting for ack
    logic        wr;                       // Write commits this edge
    logic [3:0]  page;                     // Address page
    logic [4:0]  ch;                       // Channel index
    logic        chan_ok;                  // Channel page address valid
    logic [15:0] wval;                     // Low half after byte lanes
    assign req     = wb_req.cyc & wb_req.stb & ~ack_q;
    assign wr      = wb_req.cyc & wb_req.stb & wb_req.we & ack_q;
    assign page    = wb_req.adr[11:8];
    assign ch      = wb_req.adr[6:2];
    assign chan_ok = ~wb_req.adr[7];

    // Write strobes per register class
    logic wr_data;                         // Data write, routed by A/B
    logic wr_gain;                         // Gain trim write
    logic wr_offt;                         // Offset trim write
    logic wr_ctrl;                         // Control write
    logic wr_group0_offset_level;                         // Offset level 0 write
    logic wr_group123_offset_level;                         // Offset level 1 write
    logic wr_all;                          // Global select command
    assign wr_data = wr & chan_ok & (page == PG_DATA);
    assign wr_gain = wr & chan_ok & (page == PG_GAIN);
    assign wr_offt = wr & chan_ok & (page == PG_OFFT);
    assign wr_ctrl = wr & (wb_req.adr == OFF_CTRL);
    assign wr_group0_offset_level = wr & (wb_req.adr == OFF_GROUP0_OFFSET_LEVEL);
    assign wr_group123_offset_level = wr & (wb_req.adr == OFF_GROUP123_OFFSET_LEVEL);
    assign wr_all  = wr & (wb_req.adr == OFF_SELALL);

    // Byte lane merge against the addressed 16-bit register
    logic [15:0] old16;                    // Current value of target
    assign old16 = (page == PG_GAIN) ? gain_q[ch] :
                   (page == PG_OFFT) ? offt_q[ch] :
                   ctrl_q[CTRL_AB]   ? in_b_q[ch] : in_a_q[ch];
    assign wval = {wb_req.sel[1] ? wb_req.dat[15:8] : old16[15:8],
                   wb_req.sel[0] ? wb_req.dat[7:0]  : old16[7:0]};

    // Shared calibration datapath: one multiplier, one adder
    logic        side;                     // 0 = A, 1 = B
    logic [4:0]  ec;                       // Engine channel
    logic        hit;                      // Scan index has work
    logic [15:0] x_in;                     // Selected input word
    logic [32:0] prod;                     // x * (gain + 1)
    logic [18:0] sum;                      // Signed pre-clamp result
    logic [15:0] cal_res;                  // Clamped result
    assign side    = scan_q[5];
    assign ec      = scan_q[4:0];
    assign hit     = side ? pend_b_q[ec] : pend_a_q[ec];
    assign x_in    = side ? in_b_q[ec] : in_a_q[ec];
    assign prod    = x_in * ({1'b0, gain_q[ec]} + 17'h00001);
    assign sum     = {2'b00, prod[32:16]} + {3'b000, offt_q[ec]}
                     - CAL_MID;
    // Negative wraps set bit 18; above full scale sets bit 16 (largest sum is 0x17FFE)
    assign cal_res = sum[18] ? 16'h0000 :
                     (sum > CAL_MAX) ? 16'hFFFF : sum[15:0];

    // Read mux; hidden calibrated and final words never appear here
    logic [31:0] rdata;                    // Read value
    always_comb begin
        rdata = 32'h00000000;
        if (page == PG_GLOB) begin
            case (wb_req.adr)
                OFF_CTRL: rdata = {29'h0, ctrl_q};
                OFF_GROUP0_OFFSET_LEVEL: rdata = {18'h0, group0_offset_level_q};
                OFF_GROUP123_OFFSET_LEVEL: rdata = {18'h0, group123_offset_level_q};
                OFF_STAT: rdata = {31'h0, state_q == DCC_RUN};
                default: begin
                    if (wb_req.adr[11:2] >= OFF_SEL0[11:2] &&
                        wb_req.adr[11:2] <  OFF_SELALL[11:2]) begin
                        rdata = {24'h0, sel_q[wb_req.adr[3:2] - 2'h3]};
                    end
                end
            endcase
        end else if (chan_ok) begin
            case (page)
                PG_DATA: rdata = {16'h0, ctrl_q[CTRL_AB] ? in_b_q[ch]
                                                         : in_a_q[ch]};
                PG_RDA:  rdata = {16'h0, in_a_q[ch]};
                PG_RDB:  rdata = {16'h0, in_b_q[ch]};
                PG_GAIN: rdata = {16'h0, gain_q[ch]};
                PG_OFFT: rdata = {16'h0, offt_q[ch]};
                default: rdata = 32'h00000000;
            endcase
        end
    end

    // Bus handshake: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= rdata;
            end
        end
    end

    // Global registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= RST_CTRL;
            group0_offset_level_q <= RST_OFS;
            group123_offset_level_q <= RST_OFS;
        end else begin
            if (wr_ctrl && wb_req.sel[0]) begin
                ctrl_q <= wb_req.dat[CTRL_W-1:0];
            end
            if (wr_group0_offset_level) begin
                group0_offset_level_q <= wb_req.dat[13:0];
            end
            if (wr_group123_offset_level) begin
                group123_offset_level_q <= wb_req.dat[13:0];
            end
        end
    end

    // Per-group select registers and global force command
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : g_grp
            logic wr_sel;                  // This group's select write
            assign wr_sel = wr & (wb_req.adr ==
                            OFF_SEL0 + 12'(4 * g)) & wb_req.sel[0];
            always_ff @(posedge clk) begin
                if (srst) begin
                    sel_q[g] <= RST_SEL;
                end else if (wr_all) begin
                    sel_q[g] <= {8{wb_req.dat[0]}};
                end else if (wr_sel) begin
                    sel_q[g] <= wb_req.dat[7:0];
                end
            end
        end
    endgenerate

    // Per-channel registers, pending flags and final word
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic hit_a;                   // Engine stores A this cycle
            logic hit_b;                   // Engine stores B this cycle
            logic set_a;                   // New A recalculation needed
            logic set_b;                   // New B recalculation needed
            logic wr_trim;                 // Gain or offset trim write
            logic sel_b;                   // Group select bit for channel
            assign hit_a   = hit & ~side & (ec == c);
            assign hit_b   = hit &  side & (ec == c);
            assign wr_trim = (wr_gain | wr_offt) & (ch == c);
            assign set_a   = ((wr_data & (ch == c)) | wr_trim)
                             & ~ctrl_q[CTRL_AB];
            assign set_b   = ((wr_data & (ch == c)) | wr_trim)
                             &  ctrl_q[CTRL_AB];
            // Group g = c / 8, bit n = c % 8
            assign sel_b   = sel_q[c / GRP_SIZE][c % GRP_SIZE];
            always_ff @(posedge clk) begin
                if (srst) begin
                    in_a_q[c]   <= RST_INPUT;
                    in_b_q[c]   <= RST_INPUT;
                    gain_q[c]   <= RST_GAIN;
                    offt_q[c]   <= RST_OFFT;
                    cal_a_q[c]  <= 16'h0000;
                    cal_b_q[c]  <= 16'h0000;
                    final_q[c]  <= 16'h0000;
                    pend_a_q[c] <= 1'b1;
                    pend_b_q[c] <= 1'b1;
                end else begin
                    if (wr_data && ch == c && !ctrl_q[CTRL_AB]) begin
                        in_a_q[c] <= wval;
                    end
                    if (wr_data && ch == c && ctrl_q[CTRL_AB]) begin
                        in_b_q[c] <= wval;
                    end
                    if (wr_gain && ch == c) begin
                        gain_q[c] <= wval;
                    end
                    if (wr_offt && ch == c) begin
                        offt_q[c] <= wval;
                    end
                    // Only the engine writes the calibrated words
                    if (hit_a) begin
                        cal_a_q[c] <= cal_res;
                    end
                    if (hit_b) begin
                        cal_b_q[c] <= cal_res;
                    end
                    // A new write wins over the engine's clear
                    pend_a_q[c] <= set_a | (pend_a_q[c] & ~hit_a);
                    pend_b_q[c] <= set_b | (pend_b_q[c] & ~hit_b);
                    // Final word from the selected calibrated word
                    final_q[c] <= sel_b ? cal_b_q[c]
                                        : cal_a_q[c];
                end
            end
            // Output word copied while load is held low
            always_ff @(posedge clk) begin
                if (srst) begin
                    dac_words[c*16 +: 16] <= 16'h0000;
                end else if (!load_outputs_n) begin
                    dac_words[c*16 +: 16] <= final_q[c];
                end
            end
        end
    endgenerate

    // Engine: scans 64 slots, one calibration per cycle at most
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= DCC_IDLE;
            scan_q  <= 6'h00;
        end else begin
            case (state_q)
                DCC_IDLE: begin
                    if (|{pend_a_q, pend_b_q}) begin
                        state_q <= DCC_RUN;
                    end
                end
                DCC_RUN: begin
                    scan_q <= scan_q + 6'h01;
                    if (!(|{pend_a_q, pend_b_q})) begin
                        state_q <= DCC_IDLE;
                    end
                end
                default: state_q <= DCC_IDLE;
            endcase
        end
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (srst) begin
            group0_offset_level   <= RST_OFS;
            group123_offset_level <= RST_OFS;
            thermal_enable        <= 1'b0;
            power_down            <= 1'b0;
        end else begin
            group0_offset_level   <= group0_offset_level_q;
            group123_offset_level <= group123_offset_level_q;
            thermal_enable        <= ctrl_q[CTRL_TSD];
            power_down            <= ctrl_q[CTRL_PD];
        end
    end
    assign wb_ack   = ack_q;
    assign wb_dat_o = dat_q;

    // Helper terms for the checks
    logic        wr_trim_any_a;            // Trim write with A selected
    logic        wr_trim_any_b;            // Trim write with B selected
    logic        cal_res_q_zero;           // Last stored word was zero
    logic [15:0] last_store_q;             // Most recent engine result
    assign wr_trim_any_a  = (wr_gain | wr_offt) & ~ctrl_q[CTRL_AB];
    assign wr_trim_any_b  = (wr_gain | wr_offt) &  ctrl_q[CTRL_AB];
    assign cal_res_q_zero = last_store_q == 16'h0000;
    always_ff @(posedge clk) begin
        if (srst) begin
            last_store_q <= 16'h0000;
        end else if (hit) begin
            last_store_q <= cal_res;
        end
    end

    // Checks
    data_route_a: assert property (
        wr_data && ctrl_q[CTRL_AB] && wb_req.sel == 4'hF |=>
            in_b_q[$past(ch)] == $past(wb_req.dat[15:0]))
        else $error("data write not routed to input B");
    power_down_a: assert property (
        wr_ctrl && wb_req.sel[0] |=>
            ##1 power_down == $past(wb_req.dat[0], 2))
        else $error("power-down output wrong");
    pend_a_set_a: assert property (
        wr_trim_any_a |=> pend_a_q[$past(ch)])
        else $error("trim write did not schedule A");
    pend_b_set_a: assert property (
        wr_trim_any_b |=> pend_b_q[$past(ch)])
        else $error("trim write did not schedule B");
    cal_value_a: assert property (
        hit && !side |=> cal_a_q[$past(ec)] == $past(cal_res))
        else $error("calibrated A word not stored");
    sel_force_a: assert property (
        wr_all |=> sel_q[3] == {8{$past(wb_req.dat[0])}} &&
                   sel_q[0] == sel_q[3])
        else $error("global select command failed");
    final_mux_a: assert property (
        1'b1 |=> final_q[9] == ($past(sel_q[1][1]) ? $past(cal_b_q[9])
                                                   : $past(cal_a_q[9])))
        else $error("final word not from selected source");
    load_copy_a: assert property (
        !load_outputs_n |=> dac_words[15:0] == $past(final_q[0]))
        else $error("output word not loaded");
    clamp_range_a: assert property (
        hit && sum[18] |=> cal_res_q_zero)
        else $error("underflow not clamped to zero");
    ack_pulse_a: assert property (
        req |=> ack_q ##1 !ack_q)
        else $error("ack not a one-cycle answer");

endmodule

// [dv/dcc_host.sv]
// Wishbone host model that drives the calibration register bank
`timescale 1ns/10ps
module dcc_host (
    // Clock
    input  wire logic            clk,
    // Wishbone master side
    output dcc_pkg::dcc_wb_req_t wb_req,
    input  wire logic            wb_ack,
    input  wire logic [31:0]     wb_dat_o
);
    import dcc_pkg::*;

    // Bus idle from time zero
    initial wb_req = '0;

    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do @(posedge clk); while (wb_ack !== 1'b1);
        q = wb_dat_o;
        // Released lines show the inverse so stale values never pass
        wb_req <= '{1'b0, 1'b0, ~w, ~a, 4'h0, ~d};
    endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the calibration register bank
`timescale 1ns/10ps
`define DCC_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    errors++; $display("BAD %0t got %h want %h", $time, (a), (e)); \
    end end
module tb_top;
    import dcc_pkg::*;

    typedef struct packed {
        logic        we;
        logic [11:0] adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } dcc_row_t;

    logic                 clk;             // Bench clock
    logic                 srst;            // Synchronous reset
    dcc_wb_req_t          wb_req;          // Host request
    logic                 wb_ack;          // Slave ack
    logic [31:0]          wb_dat_o;        // Read data
    logic                 load_outputs_n;  // Output load, active low
    logic [NUM_CH*16-1:0] dac_words;       // Final words
    logic [13:0]          group0_offset_level_lvl;        // Group 0 offset level
    logic [13:0]          group123_offset_level_lvl;        // Groups 1-3 offset level
    logic                 thermal_enable;  // Control bit 1
    logic                 power_down;      // Control bit 0
    int                   errors;          // Mismatches
    int                   checks_done;     // Comparisons
    int                   cycles;          // Timeout counter
    dcc_row_t             rows [14];       // Register cases

    dcc_regs dcc_regs_inst (
        .clk(clk), .srst(srst), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat_o(wb_dat_o), .load_outputs_n(load_outputs_n),
        .dac_words(dac_words), .group0_offset_level(group0_offset_level_lvl),
        .group123_offset_level(group123_offset_level_lvl),
        .thermal_enable(thermal_enable), .power_down(power_down)
    );

    dcc_host dcc_host_inst (
        .clk(clk), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // Counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        dcc_host_inst.xfer(1'b1, a, d, q);
    endtask

    // Register read and compare
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        dcc_host_inst.xfer(1'b0, a, 32'h0, q);
        `DCC_CHK(q, e)
    endtask

    // Wait until the shared engine is idle, then for the output lag
    task automatic settle();
        logic [31:0] q;
        q = 32'h1;
        repeat (2) @(posedge clk);
        while (q[0] !== 1'b0) dcc_host_inst.xfer(1'b0, OFF_STAT, 32'h0, q);
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Final word of one channel
    function automatic logic [15:0] dw(input int c);
        return dac_words[c*16 +: 16];
    endfunction

    initial begin
        errors = 0;
        checks_done = 0;
        cycles = 0;
        srst = 1'b1;
        load_outputs_n = 1'b0;
        rows = '{
            '{1'b0, 12'h000, 32'h0, 32'h0},
            '{1'b0, 12'h004, 32'h0, 32'h1555},
            '{1'b0, 12'h008, 32'h0, 32'h1555},
            '{1'b0, 12'h010, 32'h0, 32'h0},
            '{1'b0, 12'h218, 32'h0, 32'h5554},
            '{1'b0, 12'h37C, 32'h0, 32'h5554},
            '{1'b0, 12'h47C, 32'h0, 32'hFFFF},
            '{1'b0, 12'h500, 32'h0, 32'h8000},
            '{1'b0, 12'h024, 32'h0, 32'h0},
            '{1'b0, 12'h100, 32'h0, 32'h5554},
            '{1'b1, 12'h200, 32'h1234, 32'h5554},
            '{1'b1, 12'h008, 32'h3ABC, 32'h3ABC},
            '{1'b1, 12'h014, 32'hA5, 32'hA5},
            '{1'b1, 12'h000, 32'h2, 32'h2}};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        settle();
        `DCC_CHK(dw(0), 16'h5554)
        `DCC_CHK(group0_offset_level_lvl, 14'h1555)
        foreach (rows[i]) begin
            if (rows[i].we)
                wr(rows[i].adr, rows[i].dat);
            rd(rows[i].adr, rows[i].exp);
        end
        #1;
        `DCC_CHK(group123_offset_level_lvl, 14'h3ABC)
        `DCC_CHK({thermal_enable, power_down}, 2'b10)
        wr(OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        `DCC_CHK({thermal_enable, power_down}, 2'b01)
        $display("register map test done");
        wr(OFF_CTRL, 32'h0);
        wr(12'h40C, 32'h7FFF);
        wr(12'h10C, 32'h8000);
        settle();
        `DCC_CHK(dw(3), 16'h4000)
        wr(OFF_CTRL, 32'h4);
        wr(12'h10C, 32'hFFFF);
        settle();
        `DCC_CHK(dw(3), 16'h4000)
        rd(12'h30C, 32'hFFFF);
        rd(12'h20C, 32'h8000);
        wr(12'h00C, 32'h08);
        settle();
        `DCC_CHK(dw(3), 16'h7FFF)
        `DCC_CHK(dw(2), 16'h5554)
        wr(12'h50C, 32'hFFFF);
        settle();
        `DCC_CHK(dw(3), 16'hFFFE)
        wr(12'h40C, 32'hFFFF);
        settle();
        `DCC_CHK(dw(3), 16'hFFFF)
        wr(12'h00C, 32'h0);
        settle();
        `DCC_CHK(dw(3), 16'h4000)
        wr(OFF_CTRL, 32'h0);
        wr(12'h514, 32'h0);
        settle();
        `DCC_CHK(dw(5), 16'h0000)
        $display("calibration test done");
        wr(OFF_SELALL, 32'h1);
        rd(12'h018, 32'hFF);
        wr(OFF_CTRL, 32'h4);
        load_outputs_n <= 1'b1;
        wr(12'h17C, 32'h1234);
        settle();
        `DCC_CHK(dw(31), 16'h5554)
        @(posedge clk);
        load_outputs_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `DCC_CHK(dw(31), 16'h1234)
        wr(OFF_SELALL, 32'h0);
        rd(12'h00C, 32'h0);
        $display("select and load test done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_CTRL, 32'h0);
        `DCC_CHK(group123_offset_level_lvl, 14'h1555)
        $display("second reset test done");
        test_done();
    end
endmodule
